/* File: core/rdsa_ctrl.sv */
// Display controller: serial requests and text, alarm color, button menu.
// Assumes buttons are one-cycle pulses and rx_in is already synchronous.
`timescale 1ns/10ps
module rdsa_ctrl import rdsa_pkg::*; #(
	parameter int unsigned FLASH_CYC = RDSA_FLASH_CYC
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic host_mode,
	input wire logic multipoint,
	input wire logic variant_p_interface,
	input wire logic [7:0] dev_addr,
	input wire logic [15:0] baud_div,
	input wire logic signed [15:0] process_value,
	input wire logic btn_menu,
	input wire logic btn_up,
	input wire logic btn_down,
	input wire logic btn_enter,
	input wire logic btn_process,
	input wire logic rx_in,
	output logic tx_out,
	output logic tx_oe,
	output logic [31:0] disp_text,
	output rdsa_color_e disp_color,
	output rdsa_view_e disp_view,
	output rdsa_level_e menu_level,
	output rdsa_item_e menu_item,
	output logic [15:0] edit_value,
	output logic signed [15:0] peak_value,
	output logic signed [15:0] valley_value
);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rdsa_rx_e;
	typedef enum logic [2:0] {PF_HUNT, PF_ADDR0, PF_ADDR1, PF_CR1, PF_DATA} rdsa_pf_e;

	// Menu, configuration and views
	rdsa_cfg_s cfg, next_cfg;
	rdsa_level_e next_level;
	rdsa_item_e next_item;
	rdsa_view_e next_view;
	logic [15:0] next_edit;
	logic [31:0] view_cnt, next_view_cnt;
	logic signed [15:0] next_peak, next_valley;
	logic [3:0] item_idx;
	logic alarm_sel;
	logic [1:0] field_sel;
	logic [1:0] alarm_act;
	rdsa_color_e next_color;

	assign item_idx = 4'(menu_item);
	assign alarm_sel = item_idx[2];
	assign field_sel = item_idx[1:0];

	for (genvar i = 0; i < 2; i++) begin : g_alarm
		always_comb begin
			unique case (cfg.alarm[i].amode)
				RDSA_ABOVE: alarm_act[i] = process_value > cfg.alarm[i].high_limit;
				RDSA_BELOW: alarm_act[i] = process_value < cfg.alarm[i].low_limit;
				RDSA_BAND: alarm_act[i] = process_value < cfg.alarm[i].low_limit
					|| process_value > cfg.alarm[i].high_limit;
				default: alarm_act[i] = 1'b0;
			endcase
		end
	end

	always_comb begin
		next_cfg = cfg;
		next_level = menu_level;
		next_item = menu_item;
		next_view = disp_view;
		next_edit = edit_value;
		next_view_cnt = (view_cnt == 32'h0) ? 32'h0 : view_cnt - 32'h1;
		if (disp_view != V_RUN && view_cnt == 32'h0) begin
			next_view = V_RUN;
		end
		next_peak = (process_value > peak_value) ? process_value : peak_value;
		next_valley = (process_value < valley_value) ? process_value : valley_value;
		unique case (menu_level)
			LV_RUN: begin
				if (btn_menu) begin
					next_level = LV_TOP;
					next_item = IT_A1_MODE;
				end else if (btn_up) begin
					next_view = V_PEAK;
					next_view_cnt = 32'(FLASH_CYC);
				end else if (btn_down) begin
					next_view = V_VALLEY;
					next_view_cnt = 32'(FLASH_CYC);
				end
			end
			LV_TOP: begin
				if (btn_menu) begin
					next_item = (menu_item == IT_NORM_COLOR) ? IT_A1_MODE : menu_item.next();
				end else if (btn_enter) begin
					next_level = LV_SUB;
					if (menu_item == IT_NORM_COLOR) begin
						next_edit = 16'(cfg.normal_color);
					end else begin
						unique case (field_sel)
							2'h0: next_edit = 16'(cfg.alarm[alarm_sel].amode);
							2'h1: next_edit = cfg.alarm[alarm_sel].low_limit;
							2'h2: next_edit = cfg.alarm[alarm_sel].high_limit;
							2'h3: next_edit = 16'(cfg.alarm[alarm_sel].color);
						endcase
					end
				end else if (btn_up || btn_down) begin
					next_level = LV_RUN;
				end
			end
			LV_SUB: begin
				if (btn_menu) begin
					next_level = LV_TOP;
				end else if (btn_enter) begin
					next_level = LV_TOP;
					next_view = V_STORE;
					next_view_cnt = 32'(FLASH_CYC);
					if (menu_item == IT_NORM_COLOR) begin
						next_cfg.normal_color = rdsa_color_e'(edit_value[1:0]);
					end else begin
						unique case (field_sel)
							2'h0: next_cfg.alarm[alarm_sel].amode = rdsa_amode_e'(edit_value[1:0]);
							2'h1: next_cfg.alarm[alarm_sel].low_limit = edit_value;
							2'h2: next_cfg.alarm[alarm_sel].high_limit = edit_value;
							2'h3: next_cfg.alarm[alarm_sel].color = rdsa_color_e'(edit_value[1:0]);
						endcase
					end
				end else if (btn_up || btn_down) begin
					if (menu_item != IT_NORM_COLOR && field_sel[0] != field_sel[1]) begin
						// Numeric limits clamp rather than wrap
						if (btn_up && $signed(edit_value) < RDSA_VAL_MAX) begin
							next_edit = edit_value + 16'h1;
						end else if (!btn_up && $signed(edit_value) > RDSA_VAL_MIN) begin
							next_edit = edit_value - 16'h1;
						end
					end else if (btn_up) begin
						next_edit = (edit_value[1:0] == 2'h2) ? 16'h0 : edit_value + 16'h1;
					end else begin
						next_edit = (edit_value[1:0] == 2'h0) ? 16'h2 : edit_value - 16'h1;
					end
				end
			end
			default: next_level = LV_RUN;
		endcase
		if (alarm_act[0]) begin
			next_color = cfg.alarm[0].color;
		end else if (alarm_act[1]) begin
			next_color = cfg.alarm[1].color;
		end else begin
			next_color = cfg.normal_color;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg <= RDSA_CFG_RST;
			menu_level <= LV_RUN;
			menu_item <= IT_A1_MODE;
			disp_view <= V_RUN;
			edit_value <= RDSA_RST_EXT;
			view_cnt <= 32'h0;
			peak_value <= RDSA_VAL_MIN;
			valley_value <= RDSA_VAL_MAX;
			disp_color <= RDSA_GREEN;
		end else begin
			cfg <= next_cfg;
			menu_level <= next_level;
			menu_item <= next_item;
			disp_view <= next_view;
			edit_value <= next_edit;
			view_cnt <= next_view_cnt;
			peak_value <= next_peak;
			valley_value <= next_valley;
			disp_color <= next_color;
		end
	end

	// Request transmitter
	logic tx_busy, next_tx_busy, tx_multi, next_tx_multi, tx_start;
	logic [2:0] tx_idx, next_tx_idx, tx_len, next_tx_len;
	logic [3:0] tx_bit, next_tx_bit;
	logic [9:0] tx_sh, next_tx_sh;
	logic [15:0] tx_cnt, next_tx_cnt;
	logic [7:0] tx_digit, next_tx_digit, req_digit, tx_char;
	logic next_tx_out;

	// Requests only from run level so menu presses never leak onto the line
	assign tx_start = host_mode && !tx_busy && menu_level == LV_RUN && !btn_menu
		&& (btn_up || btn_down || btn_process);

	always_comb begin
		if (btn_up) begin
			req_digit = variant_p_interface ? RDSA_CMD_PEAK_P : RDSA_CMD_PEAK_T;
		end else if (btn_down) begin
			req_digit = variant_p_interface ? RDSA_CMD_VALLEY_P : RDSA_CMD_VALLEY_T;
		end else begin
			req_digit = RDSA_CMD_PROC;
		end
	end

	function automatic logic [7:0] tx_char_at(input logic [2:0] idx, input logic multi,
		input logic [7:0] addr, input logic [7:0] digit);
		logic [2:0] pos;
		pos = (multi && idx != 3'h0) ? idx - 3'h2 : idx;
		if (idx == 3'h0) begin
			return RDSA_CH_STAR;
		end else if (multi && idx == 3'h1) begin
			return RDSA_CH_ZERO | {4'h0, addr[7:4]};
		end else if (multi && idx == 3'h2) begin
			return RDSA_CH_ZERO | {4'h0, addr[3:0]};
		end else if (pos == 3'h1) begin
			return RDSA_CH_X;
		end else if (pos == 3'h2) begin
			return RDSA_CH_ZERO;
		end
		return digit;
	endfunction : tx_char_at

	always_comb begin
		next_tx_busy = tx_busy;
		next_tx_multi = tx_multi;
		next_tx_idx = tx_idx;
		next_tx_len = tx_len;
		next_tx_bit = tx_bit;
		next_tx_sh = tx_sh;
		next_tx_digit = tx_digit;
		next_tx_cnt = tx_cnt;
		tx_char = tx_char_at(tx_idx + 3'h1, tx_multi, dev_addr, tx_digit);
		if (tx_start) begin
			next_tx_busy = 1'b1;
			next_tx_multi = multipoint;
			next_tx_len = multipoint ? RDSA_LEN_MULTI : RDSA_LEN_P2P;
			next_tx_digit = req_digit;
			next_tx_idx = 3'h0;
			next_tx_bit = 4'h0;
			next_tx_cnt = baud_div;
			next_tx_sh = {1'b1, RDSA_CH_STAR, 1'b0};
		end else if (tx_busy) begin
			if (tx_cnt != 16'h0) begin
				next_tx_cnt = tx_cnt - 16'h1;
			end else begin
				next_tx_cnt = baud_div;
				if (tx_bit != RDSA_LAST_BIT) begin
					next_tx_bit = tx_bit + 4'h1;
					next_tx_sh = {1'b1, tx_sh[9:1]};
				end else if (tx_idx + 3'h1 < tx_len) begin
					next_tx_idx = tx_idx + 3'h1;
					next_tx_bit = 4'h0;
					next_tx_sh = {1'b1, tx_char, 1'b0};
				end else begin
					next_tx_busy = 1'b0;
				end
			end
		end
		next_tx_out = next_tx_busy ? next_tx_sh[0] : 1'b1;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tx_busy <= 1'b0;
			tx_multi <= 1'b0;
			tx_idx <= 3'h0;
			tx_len <= 3'h0;
			tx_bit <= 4'h0;
			tx_sh <= 10'h3FF;
			tx_digit <= 8'h00;
			tx_cnt <= 16'h0;
			tx_out <= 1'b1;
			tx_oe <= 1'b0;
		end else begin
			tx_busy <= next_tx_busy;
			tx_multi <= next_tx_multi;
			tx_idx <= next_tx_idx;
			tx_len <= next_tx_len;
			tx_bit <= next_tx_bit;
			tx_sh <= next_tx_sh;
			tx_digit <= next_tx_digit;
			tx_cnt <= next_tx_cnt;
			tx_out <= next_tx_out;
			tx_oe <= next_tx_busy;
		end
	end

	// Receiver and slave-mode text framing
	rdsa_rx_e rx_st, next_rx_st;
	rdsa_pf_e pf_st, next_pf_st;
	logic [15:0] rx_cnt, next_rx_cnt;
	logic [3:0] rx_bit, next_rx_bit;
	logic [7:0] rx_sh, next_rx_sh;
	logic rx_stb, next_rx_stb, addr_ok, next_addr_ok, bank, next_bank, commit, wr_en;
	logic [2:0] txt_cnt, next_txt_cnt;
	rdsa_pf_e pf_start;

	assign pf_start = multipoint ? PF_HUNT : PF_DATA;

	always_comb begin
		next_rx_st = rx_st;
		next_rx_cnt = (rx_cnt == 16'h0) ? 16'h0 : rx_cnt - 16'h1;
		next_rx_bit = rx_bit;
		next_rx_sh = rx_sh;
		next_rx_stb = 1'b0;
		unique case (rx_st)
			RX_IDLE: if (!rx_in) begin
				next_rx_st = RX_START;
				next_rx_cnt = {1'b0, baud_div[15:1]};
			end
			RX_START: if (rx_cnt == 16'h0) begin
				next_rx_st = rx_in ? RX_IDLE : RX_BITS;
				next_rx_cnt = baud_div;
				next_rx_bit = 4'h0;
			end
			RX_BITS: if (rx_cnt == 16'h0) begin
				next_rx_sh = {rx_in, rx_sh[7:1]};
				next_rx_bit = rx_bit + 4'h1;
				next_rx_cnt = baud_div;
				if (rx_bit + 4'h1 == RDSA_DATA_BITS) begin
					next_rx_st = RX_STOP;
				end
			end
			RX_STOP: if (rx_cnt == 16'h0) begin
				next_rx_st = RX_IDLE;
				next_rx_stb = rx_in;
			end
			default: next_rx_st = RX_IDLE;
		endcase
	end

	always_comb begin
		next_pf_st = pf_st;
		next_addr_ok = addr_ok;
		next_txt_cnt = txt_cnt;
		next_bank = bank;
		commit = 1'b0;
		wr_en = 1'b0;
		if (host_mode) begin
			next_pf_st = pf_start;
			next_addr_ok = !multipoint;
			next_txt_cnt = 3'h0;
		end else if (rx_stb) begin
			unique case (pf_st)
				PF_HUNT: if (rx_sh == RDSA_CH_STAR) begin
					next_pf_st = PF_ADDR0;
				end
				PF_ADDR0: begin
					next_pf_st = PF_ADDR1;
					next_addr_ok = rx_sh == (RDSA_CH_ZERO | {4'h0, dev_addr[7:4]});
				end
				PF_ADDR1: begin
					next_pf_st = PF_CR1;
					next_addr_ok = addr_ok && rx_sh == (RDSA_CH_ZERO | {4'h0, dev_addr[3:0]});
				end
				PF_CR1: begin
					next_pf_st = (rx_sh == RDSA_CH_CR) ? PF_DATA : PF_HUNT;
					next_txt_cnt = 3'h0;
				end
				PF_DATA: if (rx_sh == RDSA_CH_CR) begin
					commit = addr_ok && txt_cnt == RDSA_TEXT_LEN;
					next_bank = bank ^ commit;
					next_txt_cnt = 3'h0;
					next_pf_st = pf_start;
					next_addr_ok = !multipoint;
				end else if (txt_cnt != 3'h7) begin
					// Overlong text saturates the count so the frame is dropped
					wr_en = txt_cnt < RDSA_TEXT_LEN;
					next_txt_cnt = txt_cnt + 3'h1;
				end
				default: next_pf_st = pf_start;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rx_st <= RX_IDLE;
			rx_cnt <= 16'h0;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rx_stb <= 1'b0;
			pf_st <= PF_HUNT;
			addr_ok <= 1'b0;
			txt_cnt <= 3'h0;
			bank <= 1'b0;
		end else begin
			rx_st <= next_rx_st;
			rx_cnt <= next_rx_cnt;
			rx_bit <= next_rx_bit;
			rx_sh <= next_rx_sh;
			rx_stb <= next_rx_stb;
			pf_st <= next_pf_st;
			addr_ok <= next_addr_ok;
			txt_cnt <= next_txt_cnt;
			bank <= next_bank;
		end
	end

	rdsa_text_mem u_text (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.wr_en(wr_en),
		.wr_addr({~bank, txt_cnt[1:0]}),
		.wr_data(rx_sh),
		.rd_bank(bank),
		.rd_text(disp_text)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	chk_peak_cmd: assert property (tx_start && btn_up |=> tx_digit == ($past(variant_p_interface) ? 8'h33 : 8'h32))
		else $error("peak request digit wrong");
	chk_valley_cmd: assert property (tx_start && !btn_up && btn_down |=> tx_digit == ($past(variant_p_interface) ? 8'h34 : 8'h33))
		else $error("valley request digit wrong");
	chk_proc_cmd: assert property (tx_start && !btn_up && !btn_down |=> tx_digit == 8'h31 ##1 tx_oe)
		else $error("process request digit wrong");
	chk_multi_len: assert property (tx_start |=> tx_len == ($past(multipoint) ? 3'h6 : 3'h4) && !tx_out)
		else $error("request frame length wrong");
	chk_text_count: assert property (commit |-> txt_cnt == 3'h4 ##1 bank != $past(bank))
		else $error("text committed with wrong count");
	chk_addr_match: assert property (rx_stb && pf_st == PF_ADDR0 && rx_sh != (8'h30 | {4'h0, dev_addr[7:4]})
		|=> !addr_ok)
		else $error("text accepted for another address");
	chk_color_prio: assert property (alarm_act[0] |=> disp_color == $past(cfg.alarm[0].color))
		else $error("first alarm color not shown");
	chk_color_norm: assert property (alarm_act == 2'b00 |=> disp_color == $past(cfg.normal_color))
		else $error("normal color not shown");
	chk_item_wrap: assert property (menu_level == LV_TOP && btn_menu && menu_item == IT_NORM_COLOR
		|=> menu_item == IT_A1_MODE)
		else $error("menu item did not wrap");
	chk_edit_discard: assert property (menu_level == LV_SUB && btn_menu |=> menu_level == LV_TOP && $stable(cfg))
		else $error("escaped edit changed config");
	chk_top_exit: assert property (menu_level == LV_TOP && !btn_menu && !btn_enter && (btn_up || btn_down)
		|=> menu_level == LV_RUN)
		else $error("top level did not return to run");
	chk_peak_flash: assert property (menu_level == LV_RUN && !btn_menu && btn_up |=> disp_view == V_PEAK)
		else $error("peak flash missing");
	chk_store_flash: assert property (menu_level == LV_SUB && !btn_menu && btn_enter
		|=> disp_view == V_STORE && menu_level == LV_TOP)
		else $error("store flash missing");

	cov_text_commit: cover property (commit);
	cov_multi_request: cover property (tx_start && multipoint ##1 tx_busy [*8]);
	cov_store: cover property (menu_level == LV_SUB && btn_enter);
	cov_both_alarms: cover property (alarm_act == 2'b11);
endmodule : rdsa_ctrl

/* File: include/rdsa_pkg.sv */
// Constants and types of the remote serial display controller.
// Assumes a 40 MHz system clock and buttons delivered as one-cycle pulses.
// Overview of operation
// - Host up button sends asterisk, peak command.
// - Host down button sends asterisk, valley command.
// - Process request is asterisk then X01 in point-to-point.
// - Multipoint requests carry two-digit address after asterisk.
// - Multipoint slave: star, address, CR, text, CR.
// - Normal color, or color of active alarm.
// - First alarm color wins over second.
// - Above mode: alarm when value exceeds high.
// - Below mode: alarm when value under low.
// - Band mode: alarm when value outside band.
// - Menu enters configuration, then cycles items.
// - Menu during edit discards the edited value.
// - Up steps selection or increments; top exits.
// - Up in run flashes peak value.
// - Down steps selection or decrements; top exits.
// - Down in run flashes valley value.
// - Enter at top item opens its submenu.
// - Enter in submenu commits and flashes store.
package rdsa_pkg;
	localparam int unsigned RDSA_CLK_HZ = 40_000_000;
	localparam int unsigned RDSA_FLASH_MS = 1000;
	localparam int unsigned RDSA_FLASH_CYC = RDSA_CLK_HZ / 1000 * RDSA_FLASH_MS;
	localparam logic [7:0] RDSA_CH_STAR = 8'h2A;
	localparam logic [7:0] RDSA_CH_CR = 8'h0D;
	localparam logic [7:0] RDSA_CH_X = 8'h58;
	localparam logic [7:0] RDSA_CH_ZERO = 8'h30;
	localparam logic [7:0] RDSA_CMD_PROC = 8'h31;
	localparam logic [7:0] RDSA_CMD_PEAK_T = 8'h32;
	localparam logic [7:0] RDSA_CMD_PEAK_P = 8'h33;
	localparam logic [7:0] RDSA_CMD_VALLEY_T = 8'h33;
	localparam logic [7:0] RDSA_CMD_VALLEY_P = 8'h34;
	localparam logic [2:0] RDSA_LEN_P2P = 3'h4;
	localparam logic [2:0] RDSA_LEN_MULTI = 3'h6;
	localparam logic [2:0] RDSA_TEXT_LEN = 3'h4;
	localparam logic [3:0] RDSA_LAST_BIT = 4'h9;
	localparam logic [3:0] RDSA_DATA_BITS = 4'h8;
	localparam logic signed [15:0] RDSA_VAL_MIN = 16'shFC19;
	localparam logic signed [15:0] RDSA_VAL_MAX = 16'sh270F;
	localparam logic signed [15:0] RDSA_RST_LIMIT = 16'sh0000;
	localparam logic [15:0] RDSA_RST_EXT = 16'h0000;

	typedef enum logic [1:0] {RDSA_GREEN, RDSA_RED, RDSA_AMBER} rdsa_color_e;
	typedef enum logic [1:0] {RDSA_ABOVE, RDSA_BELOW, RDSA_BAND} rdsa_amode_e;
	typedef enum logic [3:0] {
		IT_A1_MODE, IT_A1_LO, IT_A1_HI, IT_A1_COLOR,
		IT_A2_MODE, IT_A2_LO, IT_A2_HI, IT_A2_COLOR, IT_NORM_COLOR
	} rdsa_item_e;
	typedef enum logic [1:0] {LV_RUN, LV_TOP, LV_SUB} rdsa_level_e;
	typedef enum logic [1:0] {V_RUN, V_PEAK, V_VALLEY, V_STORE} rdsa_view_e;

	typedef struct packed {
		rdsa_amode_e amode;
		logic signed [15:0] low_limit;
		logic signed [15:0] high_limit;
		rdsa_color_e color;
	} rdsa_alarm_s;

	typedef struct packed {
		rdsa_alarm_s [1:0] alarm;
		rdsa_color_e normal_color;
	} rdsa_cfg_s;

	localparam rdsa_cfg_s RDSA_CFG_RST = '{
		alarm: '{'{RDSA_ABOVE, RDSA_RST_LIMIT, RDSA_RST_LIMIT, RDSA_RED},
			'{RDSA_ABOVE, RDSA_RST_LIMIT, RDSA_RST_LIMIT, RDSA_AMBER}},
		normal_color: RDSA_GREEN
	};
endpackage : rdsa_pkg

/* File: core/rdsa_text_mem.sv */
// Two-bank text store for the four displayed characters.
// Assumes the writer fills the hidden bank and then flips rd_bank.
`timescale 1ns/10ps
module rdsa_text_mem import rdsa_pkg::*; (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_bank,
	output logic [31:0] rd_text
);
	logic [7:0] mem [0:7];
	logic [31:0] next_rd_text;

	always_comb begin
		next_rd_text = {mem[{rd_bank, 2'h0}], mem[{rd_bank, 2'h1}], mem[{rd_bank, 2'h2}], mem[{rd_bank, 2'h3}]};
	end

	// Spaces on reset so no unknown text is shown before the first frame
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (int k = 0; k < 8; k++) begin
				mem[k] <= 8'h20;
			end
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_text <= 32'h20202020;
		end else begin
			rd_text <= next_rd_text;
		end
	end
endmodule : rdsa_text_mem

/* File: verif/rdsa_host_model.sv */
// Serial far side: sends text bytes, decodes request bytes.
// Assumes baud_div is stable and tx_out idles high.
`timescale 1ns/10ps
module rdsa_host_model (
	input wire logic clk_sys,
	input wire logic [15:0] baud_div,
	input wire logic tx_out,
	input wire logic tx_oe,
	output logic rx_in
);
	logic [7:0] got_q[$];
	logic [7:0] b;
	initial rx_in = 1'b1;
	task automatic send_byte(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_sys);
			rx_in = f[i];
			repeat (int'(baud_div)) @(negedge clk_sys);
		end
	endtask : send_byte
	// Negedge sampling keeps clear of the registered tx edge
	always begin
		@(negedge clk_sys iff (tx_oe === 1'b1 && tx_out === 1'b0));
		repeat ((int'(baud_div) + 1) / 2) @(negedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (int'(baud_div) + 1) @(negedge clk_sys);
			b[i] = tx_out;
		end
		got_q.push_back(b);
		repeat (int'(baud_div) + 1) @(negedge clk_sys);
	end
endmodule : rdsa_host_model

/* File: verif/tb_remote_display_serial_alarm_ctrl.sv */
// Self-checking bench of the display controller.
// Assumes FLASH_CYC of 20 and a bit time of four clocks.
`timescale 1ns/10ps
module tb_remote_display_serial_alarm_ctrl import rdsa_pkg::*;;
	localparam int MENU = 4, ENTER = 3, UP = 2, DOWN = 1, PROC = 0;
	logic clk_sys, arst_n, host_mode, multipoint, variant_p_interface, rx_in, tx_out, tx_oe;
	logic [7:0] dev_addr;
	logic [15:0] baud_div, edit_value;
	logic signed [15:0] process_value, peak_value, valley_value;
	logic [4:0] btn;
	logic [31:0] disp_text, t;
	logic [47:0] got;
	rdsa_color_e disp_color;
	rdsa_view_e disp_view;
	rdsa_level_e menu_level;
	rdsa_item_e menu_item;
	int fails, num_checks, v, pk, vl;
	rdsa_ctrl #(.FLASH_CYC(20)) u_rdsa_ctrl (.clk_sys(clk_sys), .arst_n(arst_n), .host_mode(host_mode),
		.multipoint(multipoint), .variant_p_interface(variant_p_interface), .dev_addr(dev_addr),
		.baud_div(baud_div), .process_value(process_value), .btn_menu(btn[MENU]), .btn_up(btn[UP]),
		.btn_down(btn[DOWN]), .btn_enter(btn[ENTER]), .btn_process(btn[PROC]), .rx_in(rx_in),
		.tx_out(tx_out), .tx_oe(tx_oe), .disp_text(disp_text), .disp_color(disp_color),
		.disp_view(disp_view), .menu_level(menu_level), .menu_item(menu_item), .edit_value(edit_value),
		.peak_value(peak_value), .valley_value(valley_value));
	rdsa_host_model u_rdsa_host_model (.clk_sys(clk_sys), .baud_div(baud_div), .tx_out(tx_out),
		.tx_oe(tx_oe), .rx_in(rx_in));
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	task automatic press(input int i);
		@(negedge clk_sys);
		btn[i] = 1'b1;
		@(negedge clk_sys);
		btn = 5'h00;
		@(negedge clk_sys);
	endtask : press
	function automatic logic [47:0] exp_req(input logic mp, input logic vp, input int k, input logic [7:0] a);
		logic [7:0] d;
		d = (k == 0) ? 8'h31 : (k == 1) ? (vp ? 8'h33 : 8'h32) : (vp ? 8'h34 : 8'h33);
		if (mp) return {8'h2A, 8'h30 + {4'h0, a[7:4]}, 8'h30 + {4'h0, a[3:0]}, 8'h58, 8'h30, d};
		return {16'h0000, 8'h2A, 8'h58, 8'h30, d};
	endfunction : exp_req
	function automatic rdsa_color_e exp_color(input int x, input logic below1, input int lo2);
		if (below1 ? x < 0 : x > 400) return RDSA_AMBER;
		if (x > 200 || x < lo2) return RDSA_RED;
		return RDSA_GREEN;
	endfunction : exp_color
	task automatic send_text(input logic [31:0] x, input logic [7:0] a, input logic mp);
		if (mp) begin
			u_rdsa_host_model.send_byte(8'h2A);
			u_rdsa_host_model.send_byte(8'h30 + {4'h0, a[7:4]});
			u_rdsa_host_model.send_byte(8'h30 + {4'h0, a[3:0]});
			u_rdsa_host_model.send_byte(8'h0D);
		end
		for (int j = 3; j >= 0; j--) u_rdsa_host_model.send_byte(x[8*j +: 8]);
		u_rdsa_host_model.send_byte(8'h0D);
		repeat (8) @(negedge clk_sys);
	endtask : send_text
	task automatic sweep(input logic b1, input int lo2, input int c[5]);
		for (int i = 0; i < 25; i++) begin
			v = (i < 5) ? c[i] : int'($urandom_range(1998)) - 999;
			pk = (v > pk) ? v : pk;
			vl = (v < vl) ? v : vl;
			@(negedge clk_sys);
			process_value = 16'(v);
			repeat (2) @(negedge clk_sys);
			chk("disp_color", exp_color(v, b1, lo2), disp_color);
		end
		chk("peak_value", 16'(pk), peak_value);
		chk("valley_value", 16'(vl), valley_value);
	endtask : sweep
	function automatic logic [31:0] rnd_text();
		return {8'(8'h41 + $urandom_range(25)), 8'(8'h41 + $urandom_range(25)),
			8'(8'h41 + $urandom_range(25)), 8'(8'h41 + $urandom_range(25))};
	endfunction : rnd_text
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		fails++;
		$display("BAD watchdog expected finish seen hang");
		test_done();
	end
	initial begin
		{arst_n, host_mode, multipoint, variant_p_interface, btn} = '0;
		dev_addr = 8'h01;
		baud_div = 16'h0003;
		process_value = 16'sh0000;
		void'($urandom(73877));
		repeat (16) @(negedge clk_sys);
		arst_n = 1'b1;
		chk("disp_text", 32'h20202020, disp_text);
		host_mode = 1'b1;
		for (int i = 0; i < 12; i++) begin
			@(negedge clk_sys);
			{variant_p_interface, multipoint} = 2'(i);
			dev_addr = {4'($urandom_range(9)), 4'($urandom_range(9))};
			u_rdsa_host_model.got_q.delete();
			press(i / 4 == 0 ? PROC : i / 4 == 1 ? UP : DOWN);
			press(PROC);
			for (int w = 0; w < 400 && tx_oe !== 1'b0; w++) @(negedge clk_sys);
			got = '0;
			foreach (u_rdsa_host_model.got_q[j]) got = {got[39:0], u_rdsa_host_model.got_q[j]};
			chk("req_frame", exp_req(multipoint, variant_p_interface, i / 4, dev_addr), got);
		end
		$display("host request test done");
		// Host mode restarts the text parser, so every link change passes through it
		multipoint = 1'b0;
		@(negedge clk_sys);
		host_mode = 1'b0;
		t = rnd_text();
		send_text(t, dev_addr, 1'b0);
		chk("disp_text", t, disp_text);
		host_mode = 1'b1;
		multipoint = 1'b1;
		@(negedge clk_sys);
		host_mode = 1'b0;
		t = rnd_text();
		send_text(t, dev_addr, 1'b1);
		chk("disp_text", t, disp_text);
		send_text(rnd_text(), dev_addr ^ 8'h01, 1'b1);
		chk("disp_text", t, disp_text);
		$display("slave text test done");
		press(UP);
		chk("disp_view", V_PEAK, disp_view);
		repeat (24) @(negedge clk_sys);
		chk("disp_view", V_RUN, disp_view);
		press(DOWN);
		chk("disp_view", V_VALLEY, disp_view);
		repeat (24) @(negedge clk_sys);
		press(MENU);
		chk("menu_item", IT_A1_MODE, menu_item);
		press(MENU);
		press(ENTER);
		chk("menu_level", LV_SUB, menu_level);
		repeat (5) press(UP);
		chk("edit_value", 16'h0005, edit_value);
		press(MENU);
		chk("menu_item", {LV_TOP, IT_A1_LO}, {menu_level, menu_item});
		press(ENTER);
		chk("edit_value", 16'h0000, edit_value);
		press(MENU);
		press(MENU);
		press(ENTER);
		repeat (401) press(UP);
		press(DOWN);
		chk("edit_value", 16'h0190, edit_value);
		press(ENTER);
		chk("disp_view", V_STORE, disp_view);
		repeat (4) press(MENU);
		chk("menu_item", IT_A2_HI, menu_item);
		press(ENTER);
		repeat (200) press(UP);
		press(ENTER);
		press(DOWN);
		chk("menu_level", LV_RUN, menu_level);
		sweep(1'b0, -1000, '{200, 201, 400, 401, 0});
		press(MENU);
		press(ENTER);
		press(UP);
		press(ENTER);
		press(UP);
		chk("menu_level", LV_RUN, menu_level);
		sweep(1'b1, -1000, '{-1, 0, 300, 200, 201});
		press(MENU);
		repeat (4) press(MENU);
		chk("menu_item", IT_A2_MODE, menu_item);
		press(ENTER);
		repeat (2) press(UP);
		press(ENTER);
		press(MENU);
		press(ENTER);
		repeat (150) press(UP);
		press(ENTER);
		press(DOWN);
		sweep(1'b1, 150, '{149, 150, 200, 201, -1});
		$display("menu and color test done");
		test_done();
	end
endmodule : tb_remote_display_serial_alarm_ctrl
